/* File: verilog/adc_ctrl_regs.vh */
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// Register byte addresses
`define OFS_STATUS_CONTROL   12'h000
`define OFS_TRIG_CMP_CTRL    12'h004
`define OFS_RESULT_HIGH      12'h008
`define OFS_RESULT_LOW       12'h00c
`define OFS_CMP_VALUE_HIGH   12'h010
`define OFS_CMP_VALUE_LOW    12'h014
`define OFS_CONVERTER_CFG    12'h018

// First status/control fields
`define FSC_COMPLETE_BIT     7
`define FSC_CHANNEL_MSB      4
`define CHANNEL_OFF          5'h1f
`define FSC_RESET            8'h1f

// Trigger/compare control fields
`define TCC_ACTIVE_BIT       7
`define TCC_TRIGGER_BIT      6
`define TCC_CMP_EN_BIT       5
`define TCC_CMP_SENSE_BIT    4
`define TCC_RW_MASK          8'h70
`define TCC_RESET            8'h00

// Configuration fields
`define CFG_LOW_POWER_BIT    7
`define CFG_DIV_MSB          6
`define CFG_DIV_LSB          5
`define CFG_LONG_SAMPLE_BIT  4
`define CFG_MODE_MSB         3
`define CFG_MODE_LSB         2
`define CFG_CLK_MSB          1
`define CFG_CLK_LSB          0
`define CFG_RESET            8'h00

// Resolution modes
`define MODE_8BIT            2'b00
`define MODE_12BIT           2'b01
`define MODE_10BIT           2'b10

// Clock sources
`define CLK_BUS              2'b00
`define CLK_BUS_HALF         2'b01
`define CLK_ALT              2'b10
`define CLK_ASYNC            2'b11

`define CMP_RESET            8'h00
`define RESULT_RESET         8'h00

`endif

/* File: verilog/adc_config_result_compare.v */
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"

module adc_config_result_compare (
  input  wire        i_core_clk,     // Bus clock, 100 MHz
  input  wire        i_rst,          // Async reset, active high
  input  wire        i_psel,         // APB select
  input  wire        i_penable,      // APB access phase
  input  wire        i_pwrite,       // APB direction
  input  wire [11:0] i_paddr,        // APB byte address
  input  wire [31:0] i_pwdata,       // APB write data
  output wire        o_pready,       // APB ready
  output reg  [31:0] o_prdata,       // APB read data
  output wire        o_pslverr,      // APB error, unmapped address
  input  wire        i_hardware_trigger_input, // Hardware trigger pulse
  input  wire        i_alternate_clock,        // Alternate clock level
  input  wire        i_async_converter_clock,  // Internal async clock level
  input  wire        i_conv_done,    // Core finished, result valid
  input  wire [11:0] i_conv_result,  // Core result, right aligned
  output reg         o_conv_start,   // Start pulse to core
  output reg         o_conv_abort,   // Abort pulse to core
  output reg         o_converter_clock, // Derived converter clock
  output wire        o_low_power_select,  // Power configuration
  output wire        o_long_sample_select,// Sample period select
  output wire [1:0]  o_mode,          // Resolution to core
  output wire [4:0]  o_channel_select // Channel to core
);

  reg  [7:0]  fsc_r;
  reg  [7:0]  tcc_r;
  reg  [7:0]  cfg_r;
  reg  [7:0]  cvh_r;
  reg  [7:0]  cvl_r;
  reg  [11:0] result_r;
  reg         active_r;
  reg         lock_r;
  reg  [7:0]  div_cnt_r;
  reg         half_r;
  reg         src_q_r;
  reg         src_edge_r;

  wire       access  = i_psel & i_penable;
  wire       wr      = access & i_pwrite;
  wire       rd      = access & ~i_pwrite;
  wire [1:0] mode    = cfg_r[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire       narrow  = (mode == `MODE_8BIT);
  wire       cmp_en  = tcc_r[`TCC_CMP_EN_BIT];
  wire       hw_trig = tcc_r[`TCC_TRIGGER_BIT];
  wire       mapped  = (i_paddr == `OFS_STATUS_CONTROL) | (i_paddr == `OFS_TRIG_CMP_CTRL) |
                       (i_paddr == `OFS_RESULT_HIGH) | (i_paddr == `OFS_RESULT_LOW) |
                       (i_paddr == `OFS_CMP_VALUE_HIGH) | (i_paddr == `OFS_CMP_VALUE_LOW) |
                       (i_paddr == `OFS_CONVERTER_CFG);

  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign o_low_power_select   = cfg_r[`CFG_LOW_POWER_BIT];
  assign o_long_sample_select = cfg_r[`CFG_LONG_SAMPLE_BIT];
  assign o_mode               = mode;
  assign o_channel_select     = fsc_r[`FSC_CHANNEL_MSB:0];

  // Mask result to active resolution
  function [11:0] fit;
    input [1:0]  m;
    input [11:0] v;
    begin
      if (m == `MODE_12BIT)
        fit = v;
      else if (m == `MODE_10BIT)
        fit = {2'b00, v[9:0]};
      else
        fit = {4'h0, v[7:0]};
    end
  endfunction

  wire [11:0] new_res = fit(mode, i_conv_result);
  wire [11:0] cmp_val = narrow ? {4'h0, cvl_r} :
                        fit(mode, {cvh_r[3:0], cvl_r});
  wire        cmp_ge  = (new_res >= cmp_val);
  wire        cmp_ok  = tcc_r[`TCC_CMP_SENSE_BIT] ? cmp_ge : ~cmp_ge;
  wire        pass    = ~cmp_en | cmp_ok;

  wire wr_fsc   = wr & (i_paddr == `OFS_STATUS_CONTROL);
  wire rd_high  = rd & (i_paddr == `OFS_RESULT_HIGH);
  wire rd_low   = rd & (i_paddr == `OFS_RESULT_LOW);
  wire chan_on  = (i_pwdata[`FSC_CHANNEL_MSB:0] != `CHANNEL_OFF);
  wire sw_start = wr_fsc & chan_on & ~hw_trig;
  wire hw_start = hw_trig & i_hardware_trigger_input & ~active_r & ~wr_fsc &
                  (o_channel_select != `CHANNEL_OFF);
  wire done     = i_conv_done & active_r & ~wr_fsc;

  // Converter clock source and divider
  reg src_lvl;
  always @* begin
    case (cfg_r[`CFG_CLK_MSB:`CFG_CLK_LSB])
      `CLK_BUS:      src_lvl = 1'b1;
      `CLK_BUS_HALF: src_lvl = half_r;
      `CLK_ALT:      src_lvl = i_alternate_clock;
      default:       src_lvl = i_async_converter_clock;
    endcase
  end

  wire src_tick = (cfg_r[`CFG_CLK_MSB:`CFG_CLK_LSB] == `CLK_BUS) ? 1'b1 :
                  (src_lvl & ~src_q_r);
  reg [7:0] div_lim;
  always @* begin
    case (cfg_r[`CFG_DIV_MSB:`CFG_DIV_LSB])
      2'b00:   div_lim = 8'h00;
      2'b01:   div_lim = 8'h01;
      2'b10:   div_lim = 8'h03;
      default: div_lim = 8'h07;
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      half_r            <= 1'b0;
      src_q_r           <= 1'b0;
      src_edge_r        <= 1'b0;
      div_cnt_r         <= 8'h00;
      o_converter_clock <= 1'b0;
    end else begin
      half_r     <= ~half_r;
      src_q_r    <= src_lvl;
      src_edge_r <= src_tick;
      if (src_edge_r) begin
        if (cfg_r[`CFG_DIV_MSB:`CFG_DIV_LSB] == 2'b00) begin
          o_converter_clock <= ~o_converter_clock;
        end else if (div_cnt_r >= div_lim) begin
          div_cnt_r         <= 8'h00;
          o_converter_clock <= ~o_converter_clock;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  // Registers, sequencing and results
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fsc_r        <= `FSC_RESET;
      tcc_r        <= `TCC_RESET;
      cfg_r        <= `CFG_RESET;
      cvh_r        <= `CMP_RESET;
      cvl_r        <= `CMP_RESET;
      result_r     <= {`RESULT_RESET, 4'h0};
      active_r     <= 1'b0;
      lock_r       <= 1'b0;
      o_conv_start <= 1'b0;
      o_conv_abort <= 1'b0;
    end else begin
      o_conv_start <= sw_start | hw_start;
      o_conv_abort <= wr_fsc & active_r;
      if (wr_fsc) begin
        fsc_r[`FSC_CHANNEL_MSB:0] <= i_pwdata[`FSC_CHANNEL_MSB:0];
        fsc_r[6:5]                <= i_pwdata[6:5];
        fsc_r[`FSC_COMPLETE_BIT]  <= 1'b0;
      end else if (done & pass) begin
        fsc_r[`FSC_COMPLETE_BIT]  <= 1'b1;
      end else if (rd_low) begin
        fsc_r[`FSC_COMPLETE_BIT]  <= 1'b0;
      end
      if (wr & (i_paddr == `OFS_TRIG_CMP_CTRL))
        tcc_r <= i_pwdata[7:0] & `TCC_RW_MASK;
      if (wr & (i_paddr == `OFS_CONVERTER_CFG))
        cfg_r <= i_pwdata[7:0];
      if (wr & (i_paddr == `OFS_CMP_VALUE_HIGH))
        cvh_r <= {4'h0, i_pwdata[3:0]};
      if (wr & (i_paddr == `OFS_CMP_VALUE_LOW))
        cvl_r <= i_pwdata[7:0];
      if (sw_start | hw_start)
        active_r <= 1'b1;
      else if (wr_fsc | done)
        active_r <= 1'b0;
      if (done & pass & ~lock_r)
        result_r <= new_res;
      if (narrow)
        lock_r <= 1'b0;
      else if (rd_high)
        lock_r <= 1'b1;
      else if (rd_low)
        lock_r <= 1'b0;
    end
  end

  always @* begin
    o_prdata = 32'h0000_0000;
    if (i_paddr == `OFS_STATUS_CONTROL)
      o_prdata[7:0] = fsc_r;
    else if (i_paddr == `OFS_TRIG_CMP_CTRL)
      o_prdata[7:0] = {active_r, tcc_r[6:0]};
    else if (i_paddr == `OFS_RESULT_HIGH)
      o_prdata[7:0] = {4'h0, result_r[11:8]};
    else if (i_paddr == `OFS_RESULT_LOW)
      o_prdata[7:0] = result_r[7:0];
    else if (i_paddr == `OFS_CMP_VALUE_HIGH)
      o_prdata[7:0] = cvh_r;
    else if (i_paddr == `OFS_CMP_VALUE_LOW)
      o_prdata[7:0] = cvl_r;
    else if (i_paddr == `OFS_CONVERTER_CFG)
      o_prdata[7:0] = cfg_r;
  end

endmodule

/* File: testbench/adc_ctrl_sva.sv */
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_ctrl_sva (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire [31:0] o_prdata,
  input wire        i_hardware_trigger_input,
  input wire        o_conv_start,
  input wire        o_conv_abort,
  input wire        o_low_power_select,
  input wire        o_long_sample_select,
  input wire [1:0]  o_mode,
  input wire [4:0]  o_channel_select
);
  wire wr = i_psel & i_penable & i_pwrite & o_pready;
  wire rd = i_psel & i_penable & ~i_pwrite & o_pready;
  reg  trig_r;
  // Shadow of trigger select
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      trig_r <= 1'b0;
    else if (wr && i_paddr == `OFS_TRIG_CMP_CTRL)
      trig_r <= i_pwdata[6];
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_fsc_wr; wr && i_paddr == `OFS_STATUS_CONTROL; endsequence
  sequence s_cfg_wr; wr && i_paddr == `OFS_CONVERTER_CFG; endsequence
  sequence s_hi_rd; rd && i_paddr == `OFS_RESULT_HIGH; endsequence
  property p_start; s_fsc_wr ##0 (i_pwdata[4:0] != 5'h1f && !trig_r) |=> o_conv_start; endproperty
  property p_off;
    s_fsc_wr ##0 (i_pwdata[4:0] == 5'h1f && !i_hardware_trigger_input) |=> !o_conv_start;
  endproperty
  property p_hw_ign; i_hardware_trigger_input && !trig_r && !wr |=> !o_conv_start; endproperty
  property p_chan; s_fsc_wr |=> o_channel_select == $past(i_pwdata[4:0]); endproperty
  property p_mode; s_cfg_wr |=> o_mode == $past(i_pwdata[3:2]); endproperty
  property p_lp; s_cfg_wr |=> o_low_power_select == $past(i_pwdata[7]); endproperty
  property p_ls; s_cfg_wr |=> o_long_sample_select == $past(i_pwdata[4]); endproperty
  property p_hi10; s_hi_rd ##0 o_mode == `MODE_10BIT |-> o_prdata[7:2] == 6'h0; endproperty
  property p_hi8; s_hi_rd ##0 o_mode == `MODE_8BIT |-> o_prdata[7:0] == 8'h0; endproperty
  property p_abort;
    o_conv_abort |-> $past(wr && i_paddr == `OFS_STATUS_CONTROL);
  endproperty
  a_start: assert property (p_start) else $error("start missing");
  a_off: assert property (p_off) else $error("start while off");
  a_hw_ign: assert property (p_hw_ign) else $error("trigger not ignored");
  a_chan: assert property (p_chan) else $error("channel wrong");
  a_mode: assert property (p_mode) else $error("mode wrong");
  a_lp: assert property (p_lp) else $error("power select wrong");
  a_ls: assert property (p_ls) else $error("sample select wrong");
  a_hi10: assert property (p_hi10) else $error("high bits set");
  a_hi8: assert property (p_hi8) else $error("high byte set");
  a_abort: assert property (p_abort) else $error("abort without write");
endmodule
bind adc_config_result_compare adc_ctrl_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_mode(o_mode),
  .i_hardware_trigger_input(i_hardware_trigger_input), .o_conv_start(o_conv_start),
  .o_conv_abort(o_conv_abort),
  .o_low_power_select(o_low_power_select), .o_long_sample_select(o_long_sample_select),
  .o_channel_select(o_channel_select));

/* File: testbench/adc_config_result_compare_tb_top.sv */
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_config_result_compare_tb_top;
  reg         clk, rst, psel, pen, pwr, hw, done, s, hit;
  reg  [11:0] paddr, res, r, v, last;
  reg  [31:0] pwdata;
  reg  [7:0]  c, hi, n0, n1, n3, nh;
  wire        cclk;
  reg  [7:0]  exp_q[$];
  wire        pready;
  wire [31:0] prdata;
  integer     bad_count, tests_run, seed, i;
  adc_config_result_compare dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(), .i_hardware_trigger_input(hw), .i_alternate_clock(1'b0),
    .i_async_converter_clock(1'b0), .i_conv_done(done), .i_conv_result(res),
    .o_conv_start(), .o_conv_abort(), .o_converter_clock(cclk), .o_low_power_select(),
    .o_long_sample_select(), .o_mode(), .o_channel_select());
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude;
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input [7:0] e, input [31:0] g);
    tests_run = tests_run + 1;
    if (g !== {24'h0, e}) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  // Oldest expectation against each read
  always @(posedge clk)
    if (psel && pen && !pwr && pready === 1'b1)
      chk(exp_q.pop_front(), prdata);
  task apb(input w, input [11:0] a, input [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input [11:0] a, input [7:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task fin(input [11:0] x);
    @(posedge clk);
    done <= 1'b1;
    res <= x;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task conv(input [11:0] x);
    apb(1'b1, `OFS_STATUS_CONTROL, 8'h00);
    fin(x);
  endtask
  // Rising edges of the converter clock over 160 bus cycles
  task ccount(input [7:0] cf, output [7:0] n);
    integer k;
    reg     p;
    begin
      apb(1'b1, `OFS_CONVERTER_CFG, cf);
      repeat (20) @(posedge clk);
      n = 8'h00;
      p = cclk;
      for (k = 0; k < 160; k = k + 1) begin
        @(posedge clk);
        if (cclk && !p) n = n + 8'h01;
        p = cclk;
      end
    end
  endtask
  task hwp;
    @(posedge clk);
    hw <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    conclude;
  end
  initial begin
    {psel, pen, pwr, hw, done, paddr, pwdata, res} = 0;
    {bad_count, tests_run} = 0;
    seed = 32'hef8e;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 1; i < 8; i = i + 1) rd(i * 4, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      c = $random(seed);
      c[3:2] = i;
      r = $random(seed);
      hi = (i == 1) ? {4'h0, r[11:8]} : (i == 2) ? {6'h0, r[9:8]} : 8'h00;
      apb(1'b1, `OFS_CONVERTER_CFG, c);
      rd(`OFS_CONVERTER_CFG, c);
      conv(r);
      rd(`OFS_STATUS_CONTROL, 8'h80);
      rd(`OFS_RESULT_HIGH, hi);
      rd(`OFS_RESULT_LOW, r[7:0]);
    end
    conv(r);
    rd(`OFS_RESULT_HIGH, {6'h0, r[9:8]});
    v = $random(seed);
    conv(v);
    rd(`OFS_RESULT_LOW, r[7:0]);
    apb(1'b1, `OFS_CONVERTER_CFG, 8'h00);
    conv(r);
    rd(`OFS_RESULT_HIGH, 8'h00);
    conv(v);
    rd(`OFS_RESULT_LOW, v[7:0]);
    apb(1'b1, `OFS_CONVERTER_CFG, 8'h04);
    last = $random(seed);
    conv(last);
    for (i = 0; i < 6; i = i + 1) begin
      s = i[0];
      v = $random(seed);
      r = (i[2:1] == 2'b01) ? v : $random(seed);
      apb(1'b1, `OFS_TRIG_CMP_CTRL, {2'b00, 1'b1, s, 4'h0});
      apb(1'b1, `OFS_CMP_VALUE_HIGH, {4'h0, v[11:8]});
      apb(1'b1, `OFS_CMP_VALUE_LOW, v[7:0]);
      conv(r);
      hit = s ? (r >= v) : (r < v);
      if (hit) last = r;
      rd(`OFS_STATUS_CONTROL, hit ? 8'h80 : 8'h00);
      rd(`OFS_RESULT_HIGH, {4'h0, last[11:8]});
      rd(`OFS_RESULT_LOW, last[7:0]);
    end
    apb(1'b1, `OFS_TRIG_CMP_CTRL, 8'h00);
    apb(1'b1, `OFS_STATUS_CONTROL, 8'h00);
    rd(`OFS_TRIG_CMP_CTRL, 8'h80);
    apb(1'b1, `OFS_STATUS_CONTROL, 8'h1f);
    hwp;
    rd(`OFS_TRIG_CMP_CTRL, 8'h00);
    apb(1'b1, `OFS_TRIG_CMP_CTRL, 8'h40);
    apb(1'b1, `OFS_STATUS_CONTROL, 8'h03);
    rd(`OFS_TRIG_CMP_CTRL, 8'h40);
    hwp;
    rd(`OFS_TRIG_CMP_CTRL, 8'hc0);
    fin(12'h0a5);
    rd(`OFS_TRIG_CMP_CTRL, 8'h40);
    ccount(8'h00, n0);
    ccount(8'h20, n1);
    ccount(8'h60, n3);
    ccount(8'h01, nh);
    chk(n0, {24'h0, n1} * 32'd2);
    chk(n0, {24'h0, n3} * 32'd8);
    chk(n0, {24'h0, nh} * 32'd2);
    conclude;
  end
endmodule
